// ### sms_params.svh
/*
 * Constants shared by both ends of the multimode serial slave link:
 * command and status field positions, master register map, divider timing.
 * Assumes a 250 MHz system clock on both ends.
 */
`ifndef SMS_PARAMS_SVH
`define SMS_PARAMS_SVH

// ==========================================================================
// byte framing
`define SMS_LAST_BIT      3'h7
`define SMS_CMD_ADDR_MSB  7
`define SMS_CMD_ADDR_LSB  5
`define SMS_CMD_RW_BIT    4
`define SMS_ST_TXE_BIT    3
`define SMS_ST_RXF_BIT    2
`define SMS_ST_ACK_BIT    1
`define SMS_BYTE_ZERO     8'h00

// ==========================================================================
// controller register map and control fields
`define SMS_REG_CTRL      4'h0
`define SMS_REG_TX        4'h4
`define SMS_REG_RX        4'h8
`define SMS_REG_STAT      4'hC
`define SMS_CTRL_SEL      0
`define SMS_CTRL_DRIVE    1
`define SMS_CTRL_CPOL     2
`define SMS_CTRL_CPHA     3
`define SMS_CTRL_MODE_LSB 4
`define SMS_CTRL_MODE_MSB 5
`define SMS_CTRL_RESET    6'h00
`define SMS_STAT_BUSY     0

// ==========================================================================
// serial clock divider
`define SMS_MCLK_NS       4
`define SMS_SCLK_HALF_NS  80
`define SMS_HALF_CYC      (`SMS_SCLK_HALF_NS / `SMS_MCLK_NS)
`define SMS_EDGE_FIRST    4'h0
`define SMS_EDGE_LAST     4'hF

`endif

// ### sms_pkg.sv
/*
 * Types shared by both ends: operating modes and slave states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sms_pkg;

    // ======================================================================
    // link modes, as selected by the user side of each end
    typedef enum logic [1:0] {
        MODE_FULL      = 2'h0,
        MODE_HALF4     = 2'h1,
        MODE_HALF3     = 2'h2,
        MODE_UNMANAGED = 2'h3
    } sms_mode_t;

    // slave transaction states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CMD  = 3'h1,
        ST_WR   = 3'h2,
        ST_RD   = 3'h3,
        ST_SKIP = 3'h4,
        ST_UNM  = 3'h5
    } sms_state_t;

endpackage

// ### sms_link_if.sv
/*
 * Four-wire serial link between controller and slave.
 * Resolves the shared data line and the slave-to-master line from the
 * drivers' enables; an undriven line reads high, as with a pull-up.
 */
`timescale 1ns/1ps

interface sms_link_if;
    logic sclk;
    logic ss_n;
    logic mosi_m;
    logic mosi_m_oe;
    logic mosi_s;
    logic mosi_s_oe;
    logic miso;
    logic miso_oe;
    logic mosi_line;
    logic miso_line;

    // ======================================================================
    // wire resolution; the master wins if both drive (a protocol fault)
    assign mosi_line = mosi_m_oe ? mosi_m : (mosi_s_oe ? mosi_s : 1'b1);
    assign miso_line = miso_oe ? miso : 1'b1;

    modport dev (
        input  sclk, ss_n, mosi_line,
        output mosi_s, mosi_s_oe, miso, miso_oe
    );

    modport host (
        input  mosi_line, miso_line,
        output sclk, ss_n, mosi_m, mosi_m_oe
    );
endinterface

// ### sms_slave.sv
/*
 * Multimode serial slave: full duplex, four-pin and three-pin half duplex
 * with command/status handshaking, and unmanaged plain shift exchange.
 * Assumes the link pins are asynchronous to I_MCLK and that the serial
 * clock half period spans well over eight system clock cycles.
 */
`timescale 1ns/1ps
`include "sms_params.svh"

module sms_slave
    import sms_pkg::*;
(
    input  wire logic       I_MCLK,
    input  wire logic       I_RSTN,
    sms_link_if.dev         LINK,
    input  wire sms_mode_t  I_MODE,
    input  wire logic       I_CPOL,
    input  wire logic       I_CPHA,
    input  wire logic [2:0] I_OWN_ADDR,
    input  wire logic       I_TX_WR,
    input  wire logic [7:0] I_TX_DATA,
    input  wire logic       I_RX_RD,
    output logic            O_TX_FULL,
    output logic            O_RX_FULL,
    output logic [7:0]      O_RX_DATA,
    output logic            O_ACTIVE
);

    // ======================================================================
    // pin synchronisers
    logic [2:0] sclk_sync_q;
    logic [1:0] ss_sync_q;
    logic [1:0] mosi_sync_q;

    // ======================================================================
    // transfer state
    sms_state_t state_q, state_d;
    sms_mode_t  mode_q, mode_d;
    logic [2:0] bit_q, bit_d;
    logic [6:0] rx_sr_q, rx_sr_d;
    logic [7:0] cur_q, cur_d;
    logic       drv_q, drv_d;
    logic       ack_q, ack_d;
    logic       out_q, out_d;
    logic       miso_oe_q, miso_oe_d;
    logic       mosi_oe_q, mosi_oe_d;
    logic [7:0] tx_data_q, tx_data_d;
    logic       tx_full_q, tx_full_d;
    logic [7:0] rx_data_q, rx_data_d;
    logic       rx_full_q, rx_full_d;
    logic       cur_is_data_q, cur_is_data_d; // read alternation: data or status next

    logic       sel;
    logic       rise;
    logic       fall;
    logic       cpha_eff;
    logic       cap;
    logic       lau;
    logic [7:0] rx_byte;
    logic       nxt_data;
    logic       nxt_drv;
    logic       store;
    logic [7:0] status;

    // inputs from the master's clock domain: two flops before any use
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            sclk_sync_q <= 3'h0;
            ss_sync_q   <= 2'h3;
            mosi_sync_q <= 2'h3;
        end else begin
            sclk_sync_q <= {sclk_sync_q[1:0], LINK.sclk};
            ss_sync_q   <= {ss_sync_q[0], LINK.ss_n};
            mosi_sync_q <= {mosi_sync_q[0], LINK.mosi_line};
        end
    end

    // edge finding on the second and third flops only
    always_comb begin
        sel      = ~ss_sync_q[1];
        rise     = sclk_sync_q[1] & ~sclk_sync_q[2];
        fall     = ~sclk_sync_q[1] & sclk_sync_q[2];
        cpha_eff = (mode_q == MODE_UNMANAGED) ? I_CPHA : 1'b1;
        cap      = (I_CPOL ^ cpha_eff) ? fall : rise;
        lau      = (I_CPOL ^ cpha_eff) ? rise : fall;
        rx_byte  = {rx_sr_q, mosi_sync_q[1]};
    end

    // next-state logic for the whole transfer engine
    always_comb begin
        state_d   = state_q;
        mode_d    = mode_q;
        bit_d     = bit_q;
        rx_sr_d   = rx_sr_q;
        cur_d     = cur_q;
        drv_d     = drv_q;
        ack_d     = ack_q;
        out_d     = out_q;
        miso_oe_d = miso_oe_q;
        mosi_oe_d = mosi_oe_q;
        tx_data_d = tx_data_q;
        tx_full_d = tx_full_q;
        rx_data_d = rx_data_q;
        rx_full_d = rx_full_q;
        cur_is_data_d = cur_is_data_q;
        nxt_data  = 1'b0;
        nxt_drv   = 1'b0;
        store     = 1'b0;
        status    = `SMS_BYTE_ZERO;
        // cpu read empties the receive side; a store below wins
        if (I_RX_RD) begin
            rx_full_d = 1'b0;
        end
        if (!sel) begin
            state_d   = ST_IDLE;
            bit_d     = 3'h0;
            drv_d     = 1'b0;
            ack_d     = 1'b0;
            miso_oe_d = 1'b0;
            mosi_oe_d = 1'b0;
            cur_is_data_d = 1'b0;
        end else if (state_q == ST_IDLE) begin
            // the slave never starts on its own, only on select
            mode_d = I_MODE;
            bit_d  = 3'h0;
            if (I_MODE == MODE_UNMANAGED) begin
                state_d   = ST_UNM;
                cur_d     = tx_data_q;
                tx_full_d = 1'b0;
                miso_oe_d = 1'b1;
            end else begin
                state_d = ST_CMD;
                status[`SMS_ST_TXE_BIT] = ~tx_full_q;
                status[`SMS_ST_RXF_BIT] = rx_full_q;
                cur_d     = status;
                miso_oe_d = (I_MODE != MODE_HALF3);
            end
            out_d = cur_d[`SMS_LAST_BIT];
        end else if (state_q != ST_SKIP) begin
            if (lau) begin
                out_d     = cur_q[3'(`SMS_LAST_BIT - bit_q)];
                mosi_oe_d = drv_q;
            end
            if (cap) begin
                rx_sr_d = rx_byte[6:0];
                bit_d   = bit_q + 3'h1;
                if (bit_q == `SMS_LAST_BIT) begin
                    // byte boundary: decide what the next byte carries
                    case (state_q)
                        ST_CMD: begin
                            ack_d = (rx_byte[`SMS_CMD_ADDR_MSB:`SMS_CMD_ADDR_LSB]
                                     == I_OWN_ADDR);
                            if (!ack_d) begin
                                state_d   = ST_SKIP;
                                miso_oe_d = 1'b0;
                            end else begin
                                state_d = rx_byte[`SMS_CMD_RW_BIT] ? ST_RD : ST_WR;
                                if (mode_q == MODE_HALF4) begin
                                    miso_oe_d = 1'b0;
                                end
                                nxt_data = rx_byte[`SMS_CMD_RW_BIT]
                                           && (mode_q != MODE_HALF3);
                                nxt_drv  = (mode_q == MODE_HALF3)
                                           || (rx_byte[`SMS_CMD_RW_BIT]
                                               && (mode_q == MODE_HALF4));
                            end
                        end
                        ST_WR: begin
                            store   = ~drv_q;
                            nxt_drv = (mode_q == MODE_HALF3) && ~drv_q;
                        end
                        ST_RD: begin
                            nxt_data = (mode_q == MODE_HALF4) || !cur_is_data_q;
                            nxt_drv  = (mode_q != MODE_FULL);
                        end
                        ST_UNM: begin
                            store    = 1'b1;
                            nxt_data = 1'b1;
                        end
                        default: begin
                            state_d = ST_SKIP;
                        end
                    endcase
                    if (store && (!rx_full_q || mode_q == MODE_UNMANAGED)) begin
                        rx_data_d = rx_byte;
                        rx_full_d = 1'b1;
                    end
                    status[`SMS_ST_TXE_BIT] = ~tx_full_q;
                    status[`SMS_ST_RXF_BIT] = rx_full_d;
                    status[`SMS_ST_ACK_BIT] = ack_d;
                    if (nxt_data) begin
                        cur_d     = tx_data_q;
                        tx_full_d = 1'b0;
                    end else begin
                        cur_d = status;
                    end
                    drv_d = nxt_drv;
                    cur_is_data_d = nxt_data;
                    if (!nxt_drv) begin
                        mosi_oe_d = 1'b0; // early release avoids a fight
                    end
                end
            end
        end
        // cpu write fills the transmit side; set wins over consumption
        if (I_TX_WR) begin
            tx_data_d = I_TX_DATA;
            tx_full_d = 1'b1;
        end
    end

    // transfer registers
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state_q       <= ST_IDLE;
            mode_q        <= MODE_FULL;
            bit_q         <= 3'h0;
            rx_sr_q       <= 7'h00;
            cur_q         <= 8'h00;
            cur_is_data_q <= 1'b0;
            drv_q         <= 1'b0;
            ack_q         <= 1'b0;
            out_q         <= 1'b0;
            miso_oe_q     <= 1'b0;
            mosi_oe_q     <= 1'b0;
            tx_data_q     <= 8'h00;
            tx_full_q     <= 1'b0;
            rx_data_q     <= 8'h00;
            rx_full_q     <= 1'b0;
        end else begin
            state_q       <= state_d;
            mode_q        <= mode_d;
            bit_q         <= bit_d;
            rx_sr_q       <= rx_sr_d;
            cur_q         <= cur_d;
            cur_is_data_q <= cur_is_data_d;
            drv_q         <= drv_d;
            ack_q         <= ack_d;
            out_q         <= out_d;
            miso_oe_q     <= miso_oe_d;
            mosi_oe_q     <= mosi_oe_d;
            tx_data_q     <= tx_data_d;
            tx_full_q     <= tx_full_d;
            rx_data_q     <= rx_data_d;
            rx_full_q     <= rx_full_d;
        end
    end

    // ======================================================================
    // outputs from flops; O_ACTIVE is decoded from state_q
    assign LINK.miso      = out_q;
    assign LINK.miso_oe   = miso_oe_q;
    assign LINK.mosi_s    = out_q;
    assign LINK.mosi_s_oe = mosi_oe_q;
    assign O_TX_FULL      = tx_full_q;
    assign O_RX_FULL      = rx_full_q;
    assign O_RX_DATA      = rx_data_q;
    assign O_ACTIVE       = (state_q != ST_IDLE);

endmodule

// ### sms_master.sv
/*
 * Serial link controller end: makes the serial clock by division, frames
 * transfers with select and moves one byte per software request.
 * Assumes software sequences command, status check and data bytes itself.
 */
`timescale 1ns/1ps
`include "sms_params.svh"

module sms_master
    import sms_pkg::*;
(
    input  wire logic       I_MCLK,
    input  wire logic       I_RSTN,
    sms_link_if.host        LINK,
    input  wire logic [3:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    output logic [7:0]      O_RDATA
);

    localparam logic [7:0] HALF_LAST = 8'(`SMS_HALF_CYC - 1);

    // ======================================================================
    // line synchronisers
    logic [1:0] miso_sync_q;
    logic [1:0] mosi_sync_q;

    // ======================================================================
    // engine and register state
    logic [5:0] ctrl_q, ctrl_d;
    logic [7:0] tx_sr_q, tx_sr_d;
    logic [6:0] rx_sr_q, rx_sr_d;
    logic [7:0] rx_data_q, rx_data_d;
    logic       busy_q, busy_d;
    logic [7:0] div_q, div_d;
    logic [3:0] edge_q, edge_d;
    logic       sclk_q, sclk_d;
    logic       oe_q, oe_d;
    logic [7:0] rdata_q, rdata_d;

    logic       cpha;
    logic       cap;
    logic       rx_in;
    sms_mode_t  mode;

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            miso_sync_q <= 2'h3;
            mosi_sync_q <= 2'h3;
        end else begin
            miso_sync_q <= {miso_sync_q[0], LINK.miso_line};
            mosi_sync_q <= {mosi_sync_q[0], LINK.mosi_line};
        end
    end

    // byte engine and register port
    always_comb begin
        ctrl_d    = ctrl_q;
        tx_sr_d   = tx_sr_q;
        rx_sr_d   = rx_sr_q;
        rx_data_d = rx_data_q;
        busy_d    = busy_q;
        div_d     = div_q;
        edge_d    = edge_q;
        sclk_d    = sclk_q;
        oe_d      = oe_q;
        rdata_d   = 8'h00;
        mode      = sms_mode_t'(ctrl_q[`SMS_CTRL_MODE_MSB:`SMS_CTRL_MODE_LSB]);
        cpha      = ctrl_q[`SMS_CTRL_CPHA];
        // shared line carries replies in half duplex only while we let go of it
        rx_in     = ((mode == MODE_HALF3 || mode == MODE_HALF4)
                     && !ctrl_q[`SMS_CTRL_DRIVE]) ? mosi_sync_q[1] : miso_sync_q[1];
        cap       = ~edge_q[0] ^ cpha;
        if (busy_q) begin
            if (div_q == HALF_LAST) begin
                div_d  = 8'h00;
                sclk_d = ~sclk_q;
                edge_d = edge_q + 4'h1;
                if (cap) begin
                    rx_sr_d = {rx_sr_q[5:0], rx_in};
                    // eighth capture falls on the last edge pair whatever the phase
                    if (edge_q[3:1] == `SMS_LAST_BIT) begin
                        rx_data_d = {rx_sr_q, rx_in};
                    end
                end else if (!(cpha && edge_q == `SMS_EDGE_FIRST)) begin
                    tx_sr_d = {tx_sr_q[6:0], 1'b0};
                end
                if (edge_q == `SMS_EDGE_LAST) begin
                    busy_d = 1'b0;
                end
            end else begin
                div_d = div_q + 8'h01;
            end
        end
        // software writes are taken only between bytes
        if (I_WR && !busy_q) begin
            case (I_ADDR)
                `SMS_REG_CTRL: begin
                    ctrl_d = I_WDATA[5:0];
                    sclk_d = I_WDATA[`SMS_CTRL_CPOL];
                    oe_d   = I_WDATA[`SMS_CTRL_DRIVE] & I_WDATA[`SMS_CTRL_SEL];
                end
                `SMS_REG_TX: begin
                    if (ctrl_q[`SMS_CTRL_SEL]) begin
                        tx_sr_d = I_WDATA;
                        busy_d  = 1'b1;
                        div_d   = 8'h00;
                        edge_d  = `SMS_EDGE_FIRST;
                        oe_d    = ctrl_q[`SMS_CTRL_DRIVE];
                    end
                end
                default: begin
                    busy_d = busy_q;
                end
            endcase
        end
        if (I_RD) begin
            case (I_ADDR)
                `SMS_REG_CTRL: rdata_d = {2'h0, ctrl_q};
                `SMS_REG_RX:   rdata_d = rx_data_q;
                `SMS_REG_STAT: rdata_d = {7'h00, busy_q};
                default:       rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ctrl_q    <= `SMS_CTRL_RESET;
            tx_sr_q   <= 8'h00;
            rx_sr_q   <= 7'h00;
            rx_data_q <= 8'h00;
            busy_q    <= 1'b0;
            div_q     <= 8'h00;
            edge_q    <= 4'h0;
            sclk_q    <= 1'b0;
            oe_q      <= 1'b0;
            rdata_q   <= 8'h00;
        end else begin
            ctrl_q    <= ctrl_d;
            tx_sr_q   <= tx_sr_d;
            rx_sr_q   <= rx_sr_d;
            rx_data_q <= rx_data_d;
            busy_q    <= busy_d;
            div_q     <= div_d;
            edge_q    <= edge_d;
            sclk_q    <= sclk_d;
            oe_q      <= oe_d;
            rdata_q   <= rdata_d;
        end
    end

    // ======================================================================
    // outputs from flops
    assign LINK.sclk      = sclk_q;
    assign LINK.ss_n      = ~ctrl_q[`SMS_CTRL_SEL];
    assign LINK.mosi_m    = tx_sr_q[7];
    assign LINK.mosi_m_oe = oe_q;
    assign O_RDATA        = rdata_q;

endmodule

// ### sms_link_properties.sv
/* assertions on the link that joins the controller and the slave
   assumes I_MODE is the slave mode input, steady within a frame */
`timescale 1ns/1ps

module sms_link_properties
    import sms_pkg::*;
(
    input  wire logic      I_MCLK,
    input  wire logic      I_RSTN,
    input  wire logic      sclk,
    input  wire logic      ss_n,
    input  wire logic      mosi_m_oe,
    input  wire logic      mosi_s_oe,
    input  wire logic      miso_oe,
    input  wire sms_mode_t I_MODE
);
    // ====================
    // serial clock toggles counted within a frame
    logic [3:0] tgl_q;
    logic [3:0] tgl_d;
    logic       sclk_q;

    always_comb begin
        tgl_d = ss_n ? 4'h0 : tgl_q + {3'h0, sclk != sclk_q};
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            tgl_q  <= 4'h0;
            sclk_q <= 1'h0;
        end else begin
            tgl_q  <= tgl_d;
            sclk_q <= sclk;
        end
    end

    // ====================
    // properties; slave reacts a few cycles late through its synchronisers
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RSTN);

    sequence s_sel;
        $fell(ss_n);
    endsequence
    sequence s_cmd_quiet;
        !mosi_s_oe [*8];
    endsequence

    chk_sclk_half: assert property (!ss_n && $changed(sclk) |=> $stable(sclk) [*8])
        else $error("serial clock half period too short");
    chk_frame_bits: assert property ($rose(ss_n) |-> tgl_q == 4'h0)
        else $error("frame ended off a byte boundary");
    chk_status_start: assert property ($fell(ss_n) && I_MODE != MODE_HALF3 |-> ##[1:8] miso_oe)
        else $error("no status driven at frame start");
    chk_half3_quiet: assert property (I_MODE == MODE_HALF3 && !ss_n |-> !miso_oe)
        else $error("slave line driven in three pin mode");
    chk_cmd_no_drive: assert property (s_sel |-> s_cmd_quiet)
        else $error("slave drives shared line in command");
    chk_master_sel: assert property ($rose(mosi_m_oe) |-> !ss_n)
        else $error("master drives data while deselected");
    chk_sclk_settle: assert property (s_sel |=> $stable(sclk) [*8])
        else $error("serial clock moved right at select");
    chk_release_idle: assert property ($rose(ss_n) |-> ##[1:8] !miso_oe && !mosi_s_oe)
        else $error("slave kept driving after deselect");
endmodule

// ### tb_spi_slave_multimode.sv
/* bench joining controller and slave over one link, with a flag model
   assumes the controller map and busy timing of the shared constants */
`timescale 1ns/1ps
`include "sms_params.svh"

module tb_spi_slave_multimode
    import sms_pkg::*;
    ;
    logic        clk, rstn, wr, rd, tx_wr, rx_rd, cpol, cpha;
    logic        tx_full, rx_full, active, m_txfull, m_rxfull;
    logic [3:0]  addr;
    logic [7:0]  wdata, tx_data, rdata, rx_data, r, t, b, m_rxdata;
    logic [2:0]  own;
    logic [15:0] lf;
    sms_mode_t   mode;
    int          n_mismatch, tests_run;

    sms_link_if lnk ();
    sms_master i_sms_master (.I_MCLK(clk), .I_RSTN(rstn), .LINK(lnk), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata));
    sms_slave i_sms_slave (.I_MCLK(clk), .I_RSTN(rstn), .LINK(lnk), .I_MODE(mode),
        .I_CPOL(cpol), .I_CPHA(cpha), .I_OWN_ADDR(own), .I_TX_WR(tx_wr),
        .I_TX_DATA(tx_data), .I_RX_RD(rx_rd), .O_TX_FULL(tx_full),
        .O_RX_FULL(rx_full), .O_RX_DATA(rx_data), .O_ACTIVE(active));
    sms_link_properties i_props (.I_MCLK(clk), .I_RSTN(rstn), .sclk(lnk.sclk),
        .ss_n(lnk.ss_n), .mosi_m_oe(lnk.mosi_m_oe), .mosi_s_oe(lnk.mosi_s_oe),
        .miso_oe(lnk.miso_oe), .I_MODE(mode));

    // ====================
    // model and helpers; status is worked out before the byte lands
    function automatic logic [7:0] st(input logic ack);
        return {4'h0, !m_txfull, m_rxfull, ack, 1'h0};
    endfunction
    function automatic logic [7:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf[7:0];
    endfunction
    function automatic logic [7:0] ctl(input logic drv, input logic sel);
        return {2'h0, mode, cpha, cpol, drv, sel};
    endfunction
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t byte got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t flag got %b exp %b", $time, g, e);
        end
    endtask
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ====================
    // register port and slave user port cycles
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 r = rdata;
    endtask
    task automatic cfg(input sms_mode_t m, input logic p, input logic h);
        @(posedge clk);
        mode <= m;
        cpol <= p;
        cpha <= h;
        #1 wr_reg(`SMS_REG_CTRL, ctl(1'h0, 1'h0));
    endtask
    // one byte over the link; poll is bounded so a stuck busy ends the run
    task automatic xb(input logic drv, input logic [7:0] d);
        int n;
        wr_reg(`SMS_REG_CTRL, ctl(drv, 1'h1));
        wr_reg(`SMS_REG_TX, d);
        r = 8'h01;
        for (n = 0; r[`SMS_STAT_BUSY] !== 1'h0; n++) begin
            if (n == 500) begin
                n_mismatch++;
                test_done();
            end
            rd_reg(`SMS_REG_STAT);
        end
        rd_reg(`SMS_REG_RX);
    endtask
    task automatic fin();
        chk1(active, 1'h1);
        wr_reg(`SMS_REG_CTRL, ctl(1'h0, 1'h0));
        repeat (10) @(posedge clk);
        chk1(active, 1'h0);
        chk1(tx_full, m_txfull);
        chk1(rx_full, m_rxfull);
    endtask
    task automatic ld(input logic [7:0] d);
        @(posedge clk);
        tx_wr   <= 1'h1;
        tx_data <= d;
        @(posedge clk);
        tx_wr    <= 1'h0;
        m_txfull = 1'h1;
    endtask
    task automatic take();
        chk8(rx_data, m_rxdata);
        @(posedge clk);
        rx_rd <= 1'h1;
        @(posedge clk);
        rx_rd <= 1'h0;
        #1 m_rxfull = 1'h0;
        chk1(rx_full, 1'h0);
    endtask
    task automatic store(input logic [7:0] d);
        if (!m_rxfull) begin
            m_rxfull = 1'h1;
            m_rxdata = d;
        end
    endtask

    // ====================
    // clock and watchdog
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        $display("[ERR] %0t watchdog expired", $time);
        n_mismatch++;
        test_done();
    end

    // ====================
    // scenarios
    initial begin
        {rstn, wr, rd, tx_wr, rx_rd, cpol, m_txfull, m_rxfull} = 8'h00;
        {addr, wdata, tx_data, m_rxdata} = 28'h0;
        {cpha, own, lf} = {1'h1, 3'h5, 16'hECE1};
        mode = MODE_FULL;
        {n_mismatch, tests_run} = 64'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        // full duplex write; second byte refused while first unread
        cfg(MODE_FULL, 1'h0, 1'h1);
        xb(1'h1, {own, 5'h00});
        chk8(r, st(1'h0));
        for (int i = 0; i < 2; i++) begin
            t = rnd();
            xb(1'h1, t);
            chk8(r, st(1'h1));
            store(t);
        end
        fin();
        take();
        // full duplex read at inverted polarity
        cfg(MODE_FULL, 1'h1, 1'h1);
        t = rnd();
        ld(t);
        xb(1'h1, {own, 5'h10});
        chk8(r, st(1'h0));
        xb(1'h1, 8'h00);
        chk8(r, t);
        m_txfull = 1'h0;
        xb(1'h1, 8'h00);
        chk8(r, st(1'h1));
        fin();
        // four pin read then write
        cfg(MODE_HALF4, 1'h0, 1'h1);
        t = rnd();
        ld(t);
        xb(1'h1, {own, 5'h10});
        chk8(r, st(1'h0));
        xb(1'h0, 8'h00);
        chk8(r, t);
        m_txfull = 1'h0;
        fin();
        xb(1'h1, {own, 5'h00});
        chk8(r, st(1'h0));
        t = rnd();
        xb(1'h1, t);
        chk8(r, 8'hFF);
        store(t);
        fin();
        take();
        // three pin write: status and data alternate on the shared line
        cfg(MODE_HALF3, 1'h1, 1'h1);
        xb(1'h1, {own, 5'h00});
        chk8(r, 8'hFF);
        for (int i = 0; i < 2; i++) begin
            xb(1'h0, 8'h00);
            chk8(r, st(1'h1));
            t = rnd();
            xb(1'h1, t);
            store(t);
        end
        fin();
        take();
        // three pin read: status, then the byte, both on the shared line
        t = rnd();
        ld(t);
        xb(1'h1, {own, 5'h10});
        chk8(r, 8'hFF);
        xb(1'h0, 8'h00);
        chk8(r, st(1'h1));
        xb(1'h0, 8'h00);
        chk8(r, t);
        m_txfull = 1'h0;
        fin();
        // foreign address: slave goes silent after the command and stores nothing
        cfg(MODE_FULL, 1'h0, 1'h1);
        xb(1'h1, {~own, 5'h00});
        chk8(r, st(1'h0));
        xb(1'h1, rnd());
        chk8(r, 8'hFF);
        fin();
        // unmanaged exchange in all four clock settings
        for (int c = 0; c < 4; c++) begin
            cfg(MODE_UNMANAGED, c[1], c[0]);
            t = rnd();
            ld(t);
            b = rnd();
            xb(1'h1, b);
            chk8(r, t);
            m_txfull = 1'h0;
            m_rxfull = 1'h1;
            m_rxdata = b;
            fin();
            take();
        end
        test_done();
    end
endmodule
